// file: hdl/avs_pkg.sv
package avs_pkg;
	// Two-wire link
	localparam logic [6:0] SLAVE_ADDR = 7'h48;
	localparam logic [7:0] ADDR_BYTE = {SLAVE_ADDR, 1'b0};
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [7:0] GRP_FIRST = 8'h01;
	localparam logic [7:0] GRP_LAST = 8'h08;
	localparam logic [7:0] GRP_INIT [1:8] = '{8'h00, 8'h52, 8'he2, 8'h88, 8'h80, 8'h51, 8'hff, 8'h3f};

	// Field positions inside the groups
	localparam int F_AV2V = 0;
	localparam int F_AV1V = 3;
	localparam int F_VIN = 0;
	localparam int F_YC = 2;
	localparam int F_SLC = 5;
	localparam int F_ITM = 7;
	localparam int F_LPF = 0;
	localparam int F_RGBX = 1;
	localparam int F_RGB = 2;
	localparam int F_CVM = 5;
	localparam int F_PBS = 0;
	localparam int F_TUN = 1;
	localparam int F_BLK = 2;
	localparam int F_FSS = 4;
	localparam int F_SLG = 6;
	localparam int F_AMUTE = 7;
	localparam int F_AV2A = 0;
	localparam int F_AV1A = 3;
	localparam int F_FRA = 6;
	localparam int F_AIN = 0;
	localparam int F_ADC = 6;
	localparam int F_VOL = 0;
	localparam int F_GPA = 6;
	localparam int F_GPB = 7;
	localparam logic [2:0] RGB_EXTERNAL = 3'h5;

	// Controller registers on APB
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_DATA_LO = 8'h04;
	localparam logic [7:0] REG_DATA_HI = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int CMD_CNT_LSB = 8;
	localparam int CMD_GO = 16;

	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int SCL_HZ = 100_000;
	localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

	typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_GRP, DS_DAT, DS_SKIP} avs_dev_e;
	typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} avs_host_e;

	// Flags codes that the switch does not accept
	function automatic logic avs_code_ok(input logic [7:0] g, input logic [7:0] b);
		case (g)
			8'h01: avs_code_ok = (b[F_AV2V +: 3] <= 3'h5) && (b[F_AV1V +: 3] <= 3'h4);
			8'h02: avs_code_ok = (b[F_YC +: 3] <= 3'h4);
			8'h03: avs_code_ok = (b[F_RGB +: 3] <= 3'h5);
			8'h05: avs_code_ok = (b[F_AV2A +: 3] <= 3'h4) && (b[F_AV1A +: 3] <= 3'h4);
			8'h06: avs_code_ok = (b[F_AIN +: 3] <= 3'h4) && (b[F_ADC +: 2] != 2'h3) && (b[5:4] != 2'h3);
			default: avs_code_ok = 1'b1;
		endcase
	endfunction
endpackage

// file: hdl/avs_link_if.sv
`timescale 1ns/1ps
interface avs_link_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// Open-drain wire: any enabled end pulls low
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev (input scl, input sda, output dev_sda_oe);
endinterface

// file: hdl/avs_device.sv
`timescale 1ns/1ps
module avs_device (
	input wire logic CLOCK,
	input wire logic RST,
	avs_link_if.dev LINK,
	input wire logic BLANKING_INPUT_PIN,
	input wire logic POWER_ON_MUTE,
	output logic [2:0] AV2_VIDEO_OUT_SEL,
	output logic [2:0] AV1_VIDEO_OUT_SEL,
	output logic [1:0] VIDEO_INPUT_SEL,
	output logic [2:0] LUMA_CHROMA_SEL,
	output logic [1:0] SLICER_SOURCE_SEL,
	output logic AV2_INPUT_CLAMP,
	output logic LPF_WIDE,
	output logic [2:0] RGB_SOURCE_SEL,
	output logic COMPOSITE_PLAYBACK_MUTE,
	output logic PLAYBACK_SOURCE_SEL,
	output logic TUNER_SEL,
	output logic BLANKING_OUTPUT,
	output logic [1:0] FUNCTION_SWITCH_LEVEL,
	output logic SLICER_GAIN_HIGH,
	output logic AUDIO_MUTE,
	output logic [2:0] AV2_AUDIO_OUT_SEL,
	output logic [2:0] AV1_AUDIO_OUT_SEL,
	output logic [1:0] FRONT_AUDIO_SEL,
	output logic [2:0] AUDIO_INPUT_SEL,
	output logic [1:0] ADC_GAIN_SEL,
	output logic [5:0] LEFT_VOLUME_ATTENUATOR,
	output logic [5:0] RIGHT_VOLUME_ATTENUATOR,
	output logic GENERAL_OUTPUT_ONE,
	output logic GENERAL_OUTPUT_THREE,
	output logic GENERAL_OUTPUT_FOUR,
	output logic [2:0] ENCODER_INPUT_CLAMP
);
	import avs_pkg::*;

	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic byte_done;
	logic in_range;
	logic wr_en;
	avs_dev_e state_r;
	logic [3:0] bit_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic ack_r;
	logic [7:0] grp_r [1:8];

	////////////////////////////////////////////////////////////////////////////////
	// Line conditions

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= LINK.scl;
			sda_q <= LINK.sda;
		end
	end

	assign scl_rise = LINK.scl & ~scl_q;
	assign scl_fall = ~LINK.scl & scl_q;
	assign start_c = LINK.scl & scl_q & sda_q & ~LINK.sda;
	assign stop_c = LINK.scl & scl_q & ~sda_q & LINK.sda;
	assign byte_done = scl_fall && (bit_r == LAST_DATA_BIT);
	assign in_range = (ptr_r >= GRP_FIRST) && (ptr_r <= GRP_LAST);
	assign wr_en = byte_done && (state_r == DS_DAT) && in_range;

	////////////////////////////////////////////////////////////////////////////////
	// Bit counter and shifter

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			bit_r <= 4'h0;
			shift_r <= 8'h00;
		end else if (start_c) begin
			// The clock fall that ends START wraps this to bit 0
			bit_r <= 4'hf;
		end else if (stop_c) begin
			bit_r <= 4'h0;
		end else begin
			if (scl_rise && bit_r < ACK_SLOT) begin
				shift_r <= {shift_r[6:0], LINK.sda};
			end
			if (scl_fall) begin
				bit_r <= (bit_r == ACK_SLOT) ? 4'h0 : bit_r + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer state and group pointer

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r <= DS_IDLE;
			ptr_r <= 8'h00;
		end else if (start_c) begin
			state_r <= DS_ADDR;
		end else if (stop_c) begin
			state_r <= DS_IDLE;
		end else if (byte_done) begin
			case (state_r)
				DS_ADDR: begin
					state_r <= (shift_r == ADDR_BYTE) ? DS_GRP : DS_SKIP;
				end
				DS_GRP: begin
					ptr_r <= shift_r;
					state_r <= DS_DAT;
				end
				DS_DAT: begin
					ptr_r <= ptr_r + 8'h01;
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledge drive, held from the fall after bit 8 to the fall after bit 9

	always_ff @(posedge CLOCK) begin
		if (RST || start_c || stop_c) begin
			ack_r <= 1'b0;
		end else if (byte_done) begin
			ack_r <= (state_r == DS_GRP) || (state_r == DS_DAT) ||
				(state_r == DS_ADDR && shift_r == ADDR_BYTE);
		end else if (scl_fall && bit_r == ACK_SLOT) begin
			ack_r <= 1'b0;
		end
	end

	assign LINK.dev_sda_oe = ack_r;

	////////////////////////////////////////////////////////////////////////////////
	// Control groups

	always_ff @(posedge CLOCK) begin
		for (int g = 1; g <= 8; g++) begin
			if (RST) begin
				grp_r[g] <= GRP_INIT[g];
			end else if (wr_en && ptr_r == 8'(g)) begin
				grp_r[g] <= shift_r;
			end
		end
	end

	assign AV2_VIDEO_OUT_SEL = grp_r[1][F_AV2V +: 3];
	assign AV1_VIDEO_OUT_SEL = grp_r[1][F_AV1V +: 3];
	assign VIDEO_INPUT_SEL = grp_r[2][F_VIN +: 2];
	assign LUMA_CHROMA_SEL = grp_r[2][F_YC +: 3];
	assign SLICER_SOURCE_SEL = grp_r[2][F_SLC +: 2];
	assign LPF_WIDE = grp_r[3][F_LPF];
	assign COMPOSITE_PLAYBACK_MUTE = grp_r[3][F_CVM];
	assign PLAYBACK_SOURCE_SEL = grp_r[4][F_PBS];
	assign TUNER_SEL = grp_r[4][F_TUN];
	assign SLICER_GAIN_HIGH = grp_r[4][F_SLG];
	assign AV2_AUDIO_OUT_SEL = grp_r[5][F_AV2A +: 3];
	assign AV1_AUDIO_OUT_SEL = grp_r[5][F_AV1A +: 3];
	assign FRONT_AUDIO_SEL = grp_r[5][F_FRA +: 2];
	assign AUDIO_INPUT_SEL = grp_r[6][F_AIN +: 3];
	assign ADC_GAIN_SEL = grp_r[6][F_ADC +: 2];
	assign LEFT_VOLUME_ATTENUATOR = grp_r[7][F_VOL +: 6];
	assign RIGHT_VOLUME_ATTENUATOR = grp_r[8][F_VOL +: 6];
	assign GENERAL_OUTPUT_ONE = grp_r[7][F_GPA];
	assign GENERAL_OUTPUT_THREE = grp_r[8][F_GPA];
	assign GENERAL_OUTPUT_FOUR = grp_r[8][F_GPB];

	////////////////////////////////////////////////////////////////////////////////
	// Derived outputs, one clock behind the groups

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			AV2_INPUT_CLAMP <= 1'b0;
			RGB_SOURCE_SEL <= RGB_EXTERNAL;
			BLANKING_OUTPUT <= 1'b0;
			FUNCTION_SWITCH_LEVEL <= 2'h0;
			AUDIO_MUTE <= 1'b1;
			ENCODER_INPUT_CLAMP <= 3'h7;
		end else begin
			// Group 2 forces clamp, group 3 forces bias, else the pin decides
			if (grp_r[2][F_ITM]) begin
				AV2_INPUT_CLAMP <= 1'b1;
			end else if (grp_r[3][F_ITM]) begin
				AV2_INPUT_CLAMP <= 1'b0;
			end else begin
				AV2_INPUT_CLAMP <= BLANKING_INPUT_PIN;
			end
			RGB_SOURCE_SEL <= grp_r[3][F_RGBX] ? RGB_EXTERNAL : grp_r[3][F_RGB +: 3];
			case (grp_r[4][F_BLK +: 2])
				2'h0: BLANKING_OUTPUT <= 1'b0;
				2'h1: BLANKING_OUTPUT <= 1'b1;
				default: BLANKING_OUTPUT <= BLANKING_INPUT_PIN;
			endcase
			FUNCTION_SWITCH_LEVEL <= grp_r[4][F_FSS +: 2];
			AUDIO_MUTE <= grp_r[4][F_AMUTE] | POWER_ON_MUTE;
			ENCODER_INPUT_CLAMP <= grp_r[7][F_GPB] ? 3'h7 : 3'h2;
		end
	end
endmodule

// file: hdl/avs_host.sv
`timescale 1ns/1ps
module avs_host (
	input wire logic CLOCK,
	input wire logic RST,
	avs_link_if.host LINK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	import avs_pkg::*;

	logic [7:0] grp_first_r;
	logic [3:0] cnt_r;
	logic [63:0] data_r;
	logic busy_r;
	logic nack_r;
	logic done_r;
	logic bad_r;
	logic [7:0] qcnt_r;
	logic tick;
	avs_host_e state_r;
	logic [1:0] q_r;
	logic [3:0] bit_r;
	logic [3:0] byte_r;
	logic [7:0] sh_r;
	logic acc;
	logic go;
	logic codes_ok;
	logic mapped;

	function automatic logic [7:0] byte_at(input logic [3:0] i, input logic [7:0] g, input logic [63:0] d);
		if (i == 4'h0) begin
			byte_at = ADDR_BYTE;
		end else if (i == 4'h1) begin
			byte_at = g;
		end else begin
			byte_at = d[8 * (i - 4'h2) +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state

	assign acc = PSEL & PENABLE & PREADY;
	assign mapped = (PADDR == REG_CMD) || (PADDR == REG_DATA_LO) ||
		(PADDR == REG_DATA_HI) || (PADDR == REG_STATUS);
	assign go = acc && PWRITE && PADDR == REG_CMD && PWDATA[CMD_GO] && !busy_r;

	// Each queued data byte checked against its group before sending
	always_comb begin
		logic [7:0] g;
		g = PWDATA[7:0];
		codes_ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < PWDATA[CMD_CNT_LSB +: 4]) begin
				codes_ok = codes_ok & avs_code_ok(8'(g + 8'(i)), data_r[8 * i +: 8]);
			end
		end
		if (PWDATA[CMD_CNT_LSB +: 4] > 4'h1 && g == 8'h02 && data_r[F_ITM] && data_r[8 + F_ITM]) begin
			codes_ok = 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
			if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
				case (PADDR)
					REG_CMD: PRDATA <= {20'h0, cnt_r, grp_first_r};
					REG_DATA_LO: PRDATA <= data_r[31:0];
					REG_DATA_HI: PRDATA <= data_r[63:32];
					REG_STATUS: PRDATA <= {28'h0, bad_r, done_r, nack_r, busy_r};
					default: PRDATA <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			data_r <= 64'h0;
			grp_first_r <= 8'h00;
			cnt_r <= 4'h0;
			bad_r <= 1'b0;
		end else if (acc && PWRITE && !busy_r) begin
			if (PADDR == REG_DATA_LO) begin
				data_r[31:0] <= PWDATA;
			end
			if (PADDR == REG_DATA_HI) begin
				data_r[63:32] <= PWDATA;
			end
			if (go) begin
				grp_first_r <= PWDATA[7:0];
				cnt_r <= (PWDATA[CMD_CNT_LSB +: 4] > 4'h8) ? 4'h8 : PWDATA[CMD_CNT_LSB +: 4];
				bad_r <= ~codes_ok;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quarter-bit enable

	always_ff @(posedge CLOCK) begin
		if (RST || state_r == HS_IDLE) begin
			qcnt_r <= 8'h00;
		end else begin
			qcnt_r <= (qcnt_r == QTR_LAST) ? 8'h00 : qcnt_r + 8'h01;
		end
	end

	assign tick = (qcnt_r == QTR_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// Bus engine: START, address, group, data bytes, STOP

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r <= HS_IDLE;
			LINK.scl <= 1'b1;
			LINK.host_sda_oe <= 1'b0;
			busy_r <= 1'b0;
			nack_r <= 1'b0;
			done_r <= 1'b0;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			byte_r <= 4'h0;
			sh_r <= 8'h00;
		end else if (state_r == HS_IDLE) begin
			if (go && codes_ok) begin
				state_r <= HS_START;
				busy_r <= 1'b1;
				nack_r <= 1'b0;
				done_r <= 1'b0;
				q_r <= 2'h0;
			end
		end else if (tick) begin
			q_r <= q_r + 2'h1;
			case (state_r)
				HS_START: begin
					if (q_r == 2'h0) begin
						LINK.host_sda_oe <= 1'b1;
					end
					if (q_r == 2'h2) begin
						LINK.scl <= 1'b0;
					end
					if (q_r == 2'h3) begin
						state_r <= HS_BIT;
						bit_r <= 4'h0;
						byte_r <= 4'h0;
						sh_r <= ADDR_BYTE;
					end
				end
				HS_BIT: begin
					case (q_r)
						2'h0: LINK.host_sda_oe <= (bit_r == ACK_SLOT) ? 1'b0 : ~sh_r[7];
						2'h1: LINK.scl <= 1'b1;
						2'h2: nack_r <= (bit_r == ACK_SLOT) ? LINK.sda : nack_r;
						default: begin
							LINK.scl <= 1'b0;
							if (bit_r != ACK_SLOT) begin
								sh_r <= {sh_r[6:0], 1'b0};
								bit_r <= bit_r + 4'h1;
							end else if (nack_r || byte_r == cnt_r + 4'h1) begin
								state_r <= HS_STOP;
							end else begin
								bit_r <= 4'h0;
								byte_r <= byte_r + 4'h1;
								sh_r <= byte_at(byte_r + 4'h1, grp_first_r, data_r);
							end
						end
					endcase
				end
				HS_STOP: begin
					case (q_r)
						2'h0: LINK.host_sda_oe <= 1'b1;
						2'h1: LINK.scl <= 1'b1;
						2'h2: LINK.host_sda_oe <= 1'b0;
						default: begin
							state_r <= HS_IDLE;
							busy_r <= 1'b0;
							done_r <= 1'b1;
						end
					endcase
				end
				default: state_r <= HS_IDLE;
			endcase
		end
	end
endmodule

// file: verif/avs_link_sva.sv
`timescale 1ns/1ps
module avs_link_sva (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic scl,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	logic scl_d_r;
	logic sda_d_r;
	logic in_frame_r;
	logic [3:0] bit_cnt_r;
	logic start_w;
	logic stop_w;

	assign start_w = scl && scl_d_r && sda_d_r && !sda;
	assign stop_w = scl && scl_d_r && !sda_d_r && sda;

	always_ff @(posedge CLOCK) begin
		scl_d_r <= scl;
		sda_d_r <= sda;
	end

	// Clock rises since START, wrapping after the ninth
	always_ff @(posedge CLOCK) begin
		if (RST || start_w) begin
			bit_cnt_r <= 4'h0;
		end else if (scl && !scl_d_r) begin
			bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST || stop_w) begin
			in_frame_r <= 1'b0;
		end else if (start_w) begin
			in_frame_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	scl_high_a: assert property ($rose(scl) |=> scl [*8]) else $error("clock high too short");
	scl_low_a: assert property ($fell(scl) |=> !scl [*8]) else $error("clock low too short");
	ack_slot_a: assert property ($rose(dev_sda_oe) |-> bit_cnt_r == 4'h8 && !scl)
		else $error("ack outside ninth bit");
	ack_len_a: assert property ($rose(dev_sda_oe) |-> ##[200:600] $fell(dev_sda_oe))
		else $error("ack length wrong");
	ack_wire_a: assert property (scl && dev_sda_oe |-> !host_sda_oe && !sda)
		else $error("data line not low in ack");
	ack_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("ack changed while clock high");
	ack_frame_a: assert property (dev_sda_oe |-> in_frame_r) else $error("ack outside frame");
	start_fall_a: assert property (start_w |=> scl [*8] ##[100:300] !scl)
		else $error("no clock after start");
	stop_idle_a: assert property (stop_w |-> (scl && sda) [*8]) else $error("bus not idle after stop");
endmodule

// file: verif/av_switch_serial_control_tb.sv
`timescale 1ns/1ps
module av_switch_serial_control_tb;
	import avs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, clamp, lpf, cvm, pbs, tun, blk, slg, amute, gp1, gp3, gp4;
	logic bpin = 1'b0, pom = 1'b0;
	logic [2:0] av2v, av1v, yc, rgb, av2a, av1a, ain, enc;
	logic [1:0] vin, slc, function_switch_level, fra, adc;
	logic [5:0] lvol, rvol;
	logic [7:0] g [1:8] = '{8'h00, 8'h52, 8'he2, 8'h88, 8'h80, 8'h51, 8'hff, 8'h3f};
	int errors = 0;
	int cmp_count = 0;

	always #12.5 clk = ~clk;

	avs_link_if link ();
	avs_host u_avs_host (.CLOCK(clk), .RST(rst), .LINK(link), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	avs_device u_avs_device (.CLOCK(clk), .RST(rst), .LINK(link), .BLANKING_INPUT_PIN(bpin), .POWER_ON_MUTE(pom),
		.AV2_VIDEO_OUT_SEL(av2v), .AV1_VIDEO_OUT_SEL(av1v), .VIDEO_INPUT_SEL(vin), .LUMA_CHROMA_SEL(yc),
		.SLICER_SOURCE_SEL(slc), .AV2_INPUT_CLAMP(clamp), .LPF_WIDE(lpf), .RGB_SOURCE_SEL(rgb),
		.COMPOSITE_PLAYBACK_MUTE(cvm), .PLAYBACK_SOURCE_SEL(pbs), .TUNER_SEL(tun), .BLANKING_OUTPUT(blk),
		.FUNCTION_SWITCH_LEVEL(function_switch_level), .SLICER_GAIN_HIGH(slg), .AUDIO_MUTE(amute), .AV2_AUDIO_OUT_SEL(av2a),
		.AV1_AUDIO_OUT_SEL(av1a), .FRONT_AUDIO_SEL(fra), .AUDIO_INPUT_SEL(ain), .ADC_GAIN_SEL(adc),
		.LEFT_VOLUME_ATTENUATOR(lvol), .RIGHT_VOLUME_ATTENUATOR(rvol), .GENERAL_OUTPUT_ONE(gp1),
		.GENERAL_OUTPUT_THREE(gp3), .GENERAL_OUTPUT_FOUR(gp4), .ENCODER_INPUT_CLAMP(enc));
	avs_link_sva u_avs_link_sva (.CLOCK(clk), .RST(rst), .scl(link.scl), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task fail(input string msg);
		errors++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Random byte with every field inside its allowed codes
	function automatic logic [7:0] legal(input int grp);
		logic [7:0] b;
		b = 8'($urandom);
		case (grp)
			1: begin b[2:0] = 3'($urandom % 6); b[5:3] = 3'($urandom % 5); end
			2: begin b[4:2] = 3'($urandom % 5); b[7] = 1'b0; end
			3: b[4:2] = 3'($urandom % 6);
			4: b[5:4] = 2'($urandom % 3);
			5: begin b[2:0] = 3'($urandom % 5); b[5:3] = 3'($urandom % 5); end
			6: begin b[2:0] = 3'($urandom % 5); b[5:4] = 2'($urandom % 3); b[7:6] = 2'($urandom % 3); end
			default: ;
		endcase
		return b;
	endfunction

	// Model outputs follow groups, blanking pin and power-on mute
	task check_outs;
		logic [56:0] act, exp;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			bpin <= i[0];
			pom <= i[1];
			repeat (3) @(posedge clk);
			act = {av2v, av1v, vin, yc, slc, clamp, lpf, rgb, cvm, pbs, tun, blk, function_switch_level, slg, amute,
				av2a, av1a, fra, ain, adc, lvol, rvol, gp1, gp3, gp4, enc};
			exp = {g[1][2:0], g[1][5:3], g[2][1:0], g[2][4:2], g[2][6:5], g[2][7] ? 1'b1 : (g[3][7] ? 1'b0 : bpin),
				g[3][0], g[3][1] ? 3'h5 : g[3][4:2], g[3][5], g[4][0], g[4][1],
				(g[4][3:2] == 2'h0) ? 1'b0 : ((g[4][3:2] == 2'h1) ? 1'b1 : bpin), g[4][5:4], g[4][6], g[4][7] | pom,
				g[5][2:0], g[5][5:3], g[5][7:6], g[6][2:0], g[6][7:6], g[7][5:0], g[8][5:0],
				g[7][6], g[8][6], g[8][7], g[7][7] ? 3'h7 : 3'h2};
			cmp_count++;
			if (act !== exp) fail("outputs differ");
		end
	endtask

	task xfer(input int first, input int cnt);
		logic [7:0] d [0:7];
		logic [31:0] rd;
		logic err;
		int n;
		n = 0;
		for (int k = 0; k < 8; k++) d[k] = legal(first + k);
		apb(1'b1, REG_DATA_LO, {d[3], d[2], d[1], d[0]}, rd, err);
		apb(1'b1, REG_DATA_HI, {d[7], d[6], d[5], d[4]}, rd, err);
		apb(1'b1, REG_CMD, {15'h0, 1'b1, 4'h0, 4'(cnt), 8'(first)}, rd, err);
		do begin
			apb(1'b0, REG_STATUS, 32'h0, rd, err);
			n++;
		end while (rd[0] !== 1'b0 && n < 10000);
		cmp_count++;
		if (rd[3:0] !== 4'h4) fail("status after transfer");
		apb(1'b0, REG_DATA_LO, 32'h0, rd, err);
		cmp_count++;
		if (rd !== {d[3], d[2], d[1], d[0]}) fail("data readback");
		apb(1'b0, REG_CMD, 32'h0, rd, err);
		cmp_count++;
		if (rd !== {20'h0, 4'(cnt), 8'(first)}) fail("command readback");
		for (int k = 0; k < cnt; k++) if (first + k <= 8) g[first + k] = d[k];
		check_outs;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int bad_first [3] = '{1, 2, 6};
		logic [31:0] bad_lo [3] = '{32'h6, 32'h8080, 32'hc1};
		logic [31:0] rd;
		logic err;
		void'($urandom(32'hed37db8f));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		check_outs;
		apb(1'b0, 8'h10, 32'h0, rd, err);
		cmp_count++;
		if (err !== 1'b1 || rd !== 32'h0) fail("unmapped read");
		xfer(1, 2);
		xfer(3, 2);
		xfer(5, 2);
		xfer(7, 3);
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, REG_DATA_LO, bad_lo[j], rd, err);
			apb(1'b1, REG_CMD, {15'h0, 1'b1, 8'h2, 8'(bad_first[j])}, rd, err);
			apb(1'b0, REG_STATUS, 32'h0, rd, err);
			cmp_count++;
			if (rd[3] !== 1'b1 || rd[0] !== 1'b0) fail("prohibited code accepted");
			check_outs;
		end
		summarize;
	end

	initial begin
		repeat (95000) @(posedge clk);
		fail("watchdog");
		summarize;
	end
endmodule
